// ---- rtl/tef_pkg.sv ----
/*
  Shared constants and carriers for the trace event and fault control block.
  Assumes one core clock domain and an execution pipeline on that clock.
*/
`default_nettype none
package tef_pkg;
  localparam int TC_W = 32;
  // Trace control mode bits, one per trace kind.
  localparam int MODE_INSN = 1;
  localparam int MODE_BRANCH = 2;
  localparam int MODE_CALL = 3;
  localparam int MODE_RETURN = 4;
  localparam int MODE_PRERET = 5;
  localparam int MODE_SUPER = 6;
  localparam int MODE_BRKPT = 7;
  // Event flag bits sit at mode position plus this offset.
  localparam int EVT_OFS = 16;
  localparam int EVT_HWBP_LO = 24;
  localparam int EVT_HWBP_HI = 27;
  localparam logic [31:0] TC_RESERVED_MASK = 32'hF001FF01;
  localparam logic [31:0] TC_RESET = 32'h00000000;
  localparam int FRAME_PRERET_BIT = 3;
  localparam int RTYPE_W = 3;
  localparam logic [2:0] RTYPE_SUPER_A = 3'h2;
  localparam logic [2:0] RTYPE_SUPER_B = 3'h3;
  localparam int NUM_IBP = 2;
  localparam int NUM_DBP = 2;
  localparam int ADDR_W = 32;

  typedef struct packed {
    logic valid;
    logic is_branch_taken;
    logic is_call;
    logic is_bal;
    logic is_super_call;
    logic is_ret;
    logic is_mark;
    logic is_fmark;
    logic is_implicit_call;
    logic [2:0] ret_type;
    logic [ADDR_W-1:0] ip;
  } tef_retire_t;

  typedef struct packed {
    logic valid;
    logic is_store;
    logic is_load;
    logic is_fetch;
    logic [ADDR_W-1:0] addr;
  } tef_access_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic enable;
    logic [1:0] mode;
  } tef_dbp_cfg_t;
endpackage : tef_pkg
`default_nettype wire

// ---- rtl/tef_bp_match.sv ----
/*
  Hardware breakpoint comparators: two instruction and two data address units.
  Assumes configuration is held stable by the control register owner.
*/
`default_nettype none
module tef_bp_match (
  // Instruction side
  input wire tef_pkg::tef_retire_t ret_in,
  input wire logic [tef_pkg::NUM_IBP-1:0][tef_pkg::ADDR_W-1:0] ibp_addr,
  input wire logic [tef_pkg::NUM_IBP-1:0] ibp_en,
  // Data side
  input wire tef_pkg::tef_access_t acc_in,
  input wire tef_pkg::tef_dbp_cfg_t [tef_pkg::NUM_DBP-1:0] dbp_cfg,
  // Hits, instruction units low
  output logic [3:0] hit
);
  // Access classes: 0 store, 1 load or store, 2 data or fetch, 3 any access.
  function automatic logic kind_ok(input logic [1:0] m, input tef_pkg::tef_access_t a);
    case (m)
      2'h0: kind_ok = a.is_store;
      2'h1: kind_ok = a.is_store | a.is_load;
      2'h2: kind_ok = a.is_store | a.is_load | a.is_fetch;
      default: kind_ok = 1'b1;
    endcase
  endfunction : kind_ok

  always_comb begin
    for (int i = 0; i < tef_pkg::NUM_IBP; i++) begin
      hit[i] = ret_in.valid & ibp_en[i] & (ret_in.ip == ibp_addr[i]);
    end
    for (int j = 0; j < tef_pkg::NUM_DBP; j++) begin
      hit[tef_pkg::NUM_IBP+j] = acc_in.valid & dbp_cfg[j].enable &
          (acc_in.addr == dbp_cfg[j].addr) & kind_ok(dbp_cfg[j].mode, acc_in);
    end
  end
endmodule : tef_bp_match
`default_nettype wire

// ---- rtl/tef_trace_detect.sv ----
/*
  Combinational trace event detector for one retiring instruction.
  Assumes the retire record is valid for exactly one cycle per instruction.
*/
`default_nettype none
module tef_trace_detect (
  // Inputs
  input wire tef_pkg::tef_retire_t ret_in,
  input wire logic [tef_pkg::TC_W-1:0] tc,
  input wire logic [3:0] bp_hit,
  // Per-kind events, indexed by mode bit position
  output logic [7:0] evt
);
  always_comb begin
    evt = 8'h00;
    if (ret_in.valid) begin
      evt[tef_pkg::MODE_INSN] = tc[tef_pkg::MODE_INSN];
      // Taken branches only; calls, links and returns are excluded.
      evt[tef_pkg::MODE_BRANCH] = tc[tef_pkg::MODE_BRANCH] & ret_in.is_branch_taken &
          ~ret_in.is_bal & ~ret_in.is_call & ~ret_in.is_ret;
      evt[tef_pkg::MODE_RETURN] = tc[tef_pkg::MODE_RETURN] & ret_in.is_ret;
      evt[tef_pkg::MODE_SUPER] = tc[tef_pkg::MODE_SUPER] & (ret_in.is_super_call |
          (ret_in.is_ret & (ret_in.ret_type == tef_pkg::RTYPE_SUPER_A |
          ret_in.ret_type == tef_pkg::RTYPE_SUPER_B)));
      evt[tef_pkg::MODE_BRKPT] = (tc[tef_pkg::MODE_BRKPT] & (ret_in.is_mark | bp_hit[1:0] != 2'h0))
          | ret_in.is_fmark;
    end
    evt[tef_pkg::MODE_CALL] = tc[tef_pkg::MODE_CALL] & (ret_in.is_implicit_call |
        (ret_in.valid & (ret_in.is_call | ret_in.is_bal | ret_in.is_super_call)));
    evt[tef_pkg::MODE_BRKPT] = evt[tef_pkg::MODE_BRKPT] |
        (tc[tef_pkg::MODE_BRKPT] & (bp_hit[3:2] != 2'h0));
  end
endmodule : tef_trace_detect
`default_nettype wire

// ---- rtl/tef_trace_ctrl.sv ----
/*
  Trace event and trace fault control for the processor core: trace controls
  register, trace enable and pending flags, prereturn handling and fault request.
  Assumes the pipeline gives one retire record per instruction, a boundary
  strobe before each instruction, and that the fault sequencer acknowledges.
*/
`default_nettype none
module tef_trace_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Retiring instruction and memory access
  input wire tef_pkg::tef_retire_t retire,
  input wire tef_pkg::tef_access_t access,
  // About-to-execute procedure exit, with its frame prereturn flag
  input wire logic ret_next,
  input wire logic ret_next_frame_preret,
  // Instruction boundary strobe and fault sequencer handshake
  input wire logic boundary,
  input wire logic fault_ack,
  // Interrupt handler entry and return
  input wire logic intr_enter,
  input wire logic intr_return,
  // Non-trace fault handler return
  input wire logic fault_return,
  // Supervisor trace control bit cached from the supervisor stack pointer
  input wire logic super_sp_trace_bit,
  // Trace control modify instruction
  input wire logic tc_mod_en,
  input wire logic [tef_pkg::TC_W-1:0] tc_mod_mask,
  input wire logic [tef_pkg::TC_W-1:0] tc_mod_val,
  // Process controls trace enable write from software
  input wire logic trace_en_wr,
  input wire logic trace_en_val,
  // Breakpoint configuration
  input wire logic [tef_pkg::NUM_IBP-1:0][tef_pkg::ADDR_W-1:0] instruction_breakpoint_regs,
  input wire logic [tef_pkg::NUM_IBP-1:0] instruction_breakpoint_en,
  input wire tef_pkg::tef_dbp_cfg_t [tef_pkg::NUM_DBP-1:0] data_breakpoint_regs,
  // Status
  output logic [tef_pkg::TC_W-1:0] trace_ctrl_reg,
  output logic trace_enable,
  output logic fault_pending,
  // Frame link updates
  output logic frame_preret_set,
  output logic frame_preret_set_current,
  output logic frame_rtype_bit0_wr,
  output logic frame_rtype_bit0,
  // Fault request
  output logic trace_fault_req,
  output logic [7:0] trace_fault_subtype
);
  logic [3:0] bp_hit;
  logic [7:0] evt;
  logic [tef_pkg::TC_W-1:0] tc_r, tc_nxt;
  logic te_r, te_nxt;
  logic pend_r, pend_nxt;
  logic sv_te_r, sv_te_nxt;
  logic sv_pend_r, sv_pend_nxt;
  logic preret_def_r, preret_def_nxt;
  logic req_r, req_nxt;
  logic [7:0] sub_r, sub_nxt;
  logic pset_r, pset_nxt;
  logic pcur_r, pcur_nxt;
  logic rtw_r, rtw_nxt;
  logic rtv_r, rtv_nxt;

  typedef enum logic [1:0] {TEF_IDLE, TEF_REQ, TEF_WAIT} tef_state_t;
  tef_state_t st_r, st_nxt;

  tef_bp_match u_bp (
    .ret_in(retire),
    .ibp_addr(instruction_breakpoint_regs),
    .ibp_en(instruction_breakpoint_en),
    .acc_in(access),
    .dbp_cfg(data_breakpoint_regs),
    .hit(bp_hit)
  );

  tef_trace_detect u_det (
    .ret_in(retire),
    .tc(tc_r),
    .bp_hit(bp_hit),
    .evt(evt)
  );

  // Drops the instruction event when a supervisor event is present; keeps all other events.
  function automatic logic [7:0] rank(input logic [7:0] e);
    logic [7:0] grp;
    grp = 8'h00;
    grp[tef_pkg::MODE_BRKPT] = e[tef_pkg::MODE_BRKPT];
    grp[tef_pkg::MODE_BRANCH] = e[tef_pkg::MODE_BRANCH];
    grp[tef_pkg::MODE_CALL] = e[tef_pkg::MODE_CALL];
    grp[tef_pkg::MODE_RETURN] = e[tef_pkg::MODE_RETURN];
    if (e[tef_pkg::MODE_SUPER]) begin
      rank = e & ~(8'h01 << tef_pkg::MODE_INSN);
    end else if (grp != 8'h00) begin
      rank = grp | e;
    end else begin
      rank = e;
    end
  endfunction : rank

  always_comb begin
    logic [7:0] ev;
    logic pre_evt;
    ev = rank(evt);
    pre_evt = ret_next & ret_next_frame_preret & tc_r[tef_pkg::MODE_PRERET];
    tc_nxt = tc_r;
    te_nxt = te_r;
    pend_nxt = pend_r;
    sv_te_nxt = sv_te_r;
    sv_pend_nxt = sv_pend_r;
    preret_def_nxt = preret_def_r;
    st_nxt = st_r;
    req_nxt = 1'b0;
    sub_nxt = sub_r;
    pset_nxt = 1'b0;
    pcur_nxt = 1'b0;
    rtw_nxt = 1'b0;
    rtv_nxt = rtv_r;
    // Software writes first so that hardware sets in the same cycle win.
    if (tc_mod_en) begin
      tc_nxt = (tc_r & ~tc_mod_mask) | (tc_mod_val & tc_mod_mask);
    end
    if (trace_en_wr) begin
      te_nxt = trace_en_val;
    end
    if (evt[tef_pkg::MODE_CALL]) begin
      pset_nxt = ~retire.is_bal;
      pcur_nxt = retire.is_bal;
    end
    if (bp_hit != 4'h0 && tc_r[tef_pkg::MODE_BRKPT]) begin
      tc_nxt[tef_pkg::EVT_HWBP_LO +: 4] = tc_nxt[tef_pkg::EVT_HWBP_LO +: 4] | bp_hit;
    end
    if (ev != 8'h00) begin
      tc_nxt[tef_pkg::EVT_OFS +: 8] = tc_nxt[tef_pkg::EVT_OFS +: 8] | ev;
      if (te_r) begin
        pend_nxt = 1'b1;
      end
    end
    if (retire.valid && retire.is_super_call) begin
      rtw_nxt = 1'b1;
      rtv_nxt = te_r;
      te_nxt = super_sp_trace_bit;
    end
    if (retire.valid && retire.is_ret && (retire.ret_type == tef_pkg::RTYPE_SUPER_A ||
        retire.ret_type == tef_pkg::RTYPE_SUPER_B)) begin
      te_nxt = retire.ret_type[0];
    end
    // A prereturn event that meets other pending work waits for the handler return.
    if (pre_evt) begin
      if (pend_r || ev != 8'h00) begin
        preret_def_nxt = 1'b1;
      end else begin
        tc_nxt[tef_pkg::EVT_OFS + tef_pkg::MODE_PRERET] = 1'b1;
        pend_nxt = pend_nxt | te_r;
      end
    end
    if (fault_return && preret_def_r) begin
      preret_def_nxt = 1'b0;
      tc_nxt[tef_pkg::EVT_OFS + tef_pkg::MODE_PRERET] = 1'b1;
      pend_nxt = te_r;
    end
    if (intr_enter) begin
      sv_te_nxt = te_r;
      sv_pend_nxt = pend_nxt;
      te_nxt = 1'b0;
      pend_nxt = 1'b0;
    end else if (intr_return) begin
      te_nxt = sv_te_r;
      pend_nxt = sv_pend_r;
    end
    case (st_r)
      TEF_IDLE: begin
        if (boundary && pend_r) begin
          if (te_r) begin
            st_nxt = TEF_REQ;
            req_nxt = 1'b1;
            sub_nxt = tc_r[tef_pkg::EVT_OFS +: 8];
          end else begin
            // Only flags raised before this cycle go; a set in this cycle wins.
            tc_nxt[tef_pkg::EVT_OFS +: 8] = tc_nxt[tef_pkg::EVT_OFS +: 8] &
                ~tc_r[tef_pkg::EVT_OFS +: 8];
            tc_nxt[tef_pkg::EVT_HWBP_LO +: 4] = tc_nxt[tef_pkg::EVT_HWBP_LO +: 4] &
                ~tc_r[tef_pkg::EVT_HWBP_LO +: 4];
            pend_nxt = 1'b0;
          end
        end
      end
      TEF_REQ: begin
        st_nxt = TEF_WAIT;
      end
      TEF_WAIT: begin
        if (fault_ack) begin
          // Handler entry is an implicit supervisor call with tracing off.
          st_nxt = TEF_IDLE;
          te_nxt = 1'b0;
          pend_nxt = 1'b0;
          tc_nxt[tef_pkg::EVT_OFS +: 8] = 8'h00;
          tc_nxt[tef_pkg::EVT_HWBP_LO +: 4] = 4'h0;
        end
      end
      default: st_nxt = TEF_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tc_r <= tef_pkg::TC_RESET;
      te_r <= 1'b0;
      pend_r <= 1'b0;
      sv_te_r <= 1'b0;
      sv_pend_r <= 1'b0;
      preret_def_r <= 1'b0;
      st_r <= TEF_IDLE;
      req_r <= 1'b0;
      sub_r <= 8'h00;
      pset_r <= 1'b0;
      pcur_r <= 1'b0;
      rtw_r <= 1'b0;
      rtv_r <= 1'b0;
    end else begin
      tc_r <= tc_nxt;
      te_r <= te_nxt;
      pend_r <= pend_nxt;
      sv_te_r <= sv_te_nxt;
      sv_pend_r <= sv_pend_nxt;
      preret_def_r <= preret_def_nxt;
      st_r <= st_nxt;
      req_r <= req_nxt;
      sub_r <= sub_nxt;
      pset_r <= pset_nxt;
      pcur_r <= pcur_nxt;
      rtw_r <= rtw_nxt;
      rtv_r <= rtv_nxt;
    end
  end

  assign trace_ctrl_reg = tc_r;
  assign trace_enable = te_r;
  assign fault_pending = pend_r;
  assign frame_preret_set = pset_r;
  assign frame_preret_set_current = pcur_r;
  assign frame_rtype_bit0_wr = rtw_r;
  assign frame_rtype_bit0 = rtv_r;
  assign trace_fault_req = req_r;
  assign trace_fault_subtype = sub_r;
endmodule : tef_trace_ctrl
`default_nettype wire

// ---- sim/tef_seq_model.sv ----
/*
  Fault sequencer stand-in: acknowledges each trace fault request.
  Assumes the request is a one-cycle pulse on the core clock.
*/
`default_nettype none
module tef_seq_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pace select and handshake
  input wire logic slow,
  input wire logic trace_fault_req,
  output var logic fault_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_r;
  // A slow answer leaves room to show that boundaries are refused meanwhile.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_r <= 3'h0;
      fault_ack <= 1'b0;
    end else begin
      fault_ack <= (wait_r == 3'h1);
      if (trace_fault_req) begin
        wait_r <= slow ? 3'h6 : 3'h1;
      end else if (wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end
    end
  end
endmodule : tef_seq_model
`default_nettype wire

// ---- sim/tef_trace_ctrl_chk.sv ----
/*
  Port checker for the trace event and fault control block.
  Assumes one core clock and an active-high asynchronous reset.
*/
`default_nettype none
module tef_trace_ctrl_chk (
  // Clock, reset and inputs
  input wire logic core_clk,
  input wire logic rst,
  input wire tef_pkg::tef_retire_t retire,
  input wire logic boundary,
  input wire logic fault_ack,
  input wire logic intr_enter,
  input wire logic intr_return,
  input wire logic tc_mod_en,
  input wire logic trace_en_wr,
  input wire logic super_sp_trace_bit,
  // Outputs of the block
  input wire logic [tef_pkg::TC_W-1:0] trace_ctrl_reg,
  input wire logic trace_enable,
  input wire logic fault_pending,
  input wire logic frame_preret_set,
  input wire logic frame_preret_set_current,
  input wire logic frame_rtype_bit0_wr,
  input wire logic frame_rtype_bit0,
  input wire logic trace_fault_req,
  input wire logic [7:0] trace_fault_subtype
);
  timeunit 1ns;
  timeprecision 1ps;
  logic quiet;
  logic hold;
  // Software writes and fault hand-offs also move these bits, so they are excluded.
  assign quiet = !boundary && !fault_ack && !tc_mod_en;
  assign hold = !fault_ack && !intr_enter && !intr_return && !trace_en_wr;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_insn;
    retire.valid && trace_ctrl_reg[1] && quiet |=> trace_ctrl_reg[17];
  endproperty
  a_insn: assert property (p_insn)
    else $error("instruction event flag missing");
  property p_call;
    retire.valid && trace_ctrl_reg[3] && (retire.is_call || retire.is_bal)
      |=> trace_ctrl_reg[19] && (frame_preret_set || frame_preret_set_current);
  endproperty
  a_call: assert property (p_call)
    else $error("call event or frame flag missing");
  property p_pend;
    retire.valid && trace_ctrl_reg[1] && !fault_pending && quiet && hold
      |=> fault_pending == $past(trace_enable);
  endproperty
  a_pend: assert property (p_pend)
    else $error("pending flag does not follow trace enable");
  property p_req;
    trace_fault_req |-> ($past(boundary) && $past(fault_pending) && $past(trace_enable)
      && trace_fault_subtype == $past(trace_ctrl_reg[23:16])) ##1 !trace_fault_req;
  endproperty
  a_req: assert property (p_req)
    else $error("fault request without cause or too long");
  property p_ack;
    fault_ack && !retire.valid && !intr_return
      |=> !fault_pending && !trace_enable && trace_ctrl_reg[23:17] == 7'h00;
  endproperty
  a_ack: assert property (p_ack)
    else $error("handler entry left trace state set");
  property p_clr;
    boundary && fault_pending && !trace_enable && !retire.valid && !retire.is_implicit_call
      && !tc_mod_en
      |=> trace_ctrl_reg[23:16] == 8'h00 && !trace_fault_req;
  endproperty
  a_clr: assert property (p_clr)
    else $error("flags kept with tracing off");
  property p_svc;
    retire.valid && retire.is_super_call && hold |=> frame_rtype_bit0_wr
      && frame_rtype_bit0 == $past(trace_enable) && trace_enable == $past(super_sp_trace_bit);
  endproperty
  a_svc: assert property (p_svc)
    else $error("supervisor call trace enable swap wrong");
  property p_sret;
    retire.valid && retire.is_ret && retire.ret_type[2:1] == 2'h1 && hold
      |=> trace_enable == $past(retire.ret_type[0]);
  endproperty
  a_sret: assert property (p_sret)
    else $error("supervisor return trace enable wrong");
endmodule : tef_trace_ctrl_chk
bind tef_trace_ctrl tef_trace_ctrl_chk i_chk (
  .core_clk, .rst, .retire, .boundary, .fault_ack, .intr_enter, .intr_return,
  .tc_mod_en, .trace_en_wr, .super_sp_trace_bit, .trace_ctrl_reg, .trace_enable,
  .fault_pending, .frame_preret_set, .frame_preret_set_current,
  .frame_rtype_bit0_wr, .frame_rtype_bit0, .trace_fault_req, .trace_fault_subtype
);
`default_nettype wire

// ---- sim/tef_trace_ctrl_bench.sv ----
/*
  Self-checking bench for the trace event and fault control block.
  Assumes the port checker and the sequencer model are compiled alongside.
*/
`default_nettype none
module tef_trace_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  tef_pkg::tef_retire_t retire = '0;
  logic ret_next = 1'b0;
  logic ret_next_frame_preret = 1'b0;
  logic boundary = 1'b0;
  logic intr_enter = 1'b0;
  logic intr_return = 1'b0;
  logic super_sp_trace_bit = 1'b0;
  logic tc_mod_en = 1'b0;
  logic [31:0] tc_mod_mask = 32'h00FE00FE;
  logic [31:0] tc_mod_val = 32'h00000000;
  logic trace_en_wr = 1'b0;
  logic trace_en_val = 1'b0;
  logic slow = 1'b0;
  logic fault_return = 1'b0;
  logic [1:0] ibp_en = 2'h0;
  logic fault_ack, trace_enable, fault_pending, trace_fault_req;
  logic frame_preret_set, frame_preret_set_current, frame_rtype_bit0_wr, frame_rtype_bit0;
  logic [31:0] trace_ctrl_reg;
  logic [7:0] trace_fault_subtype;
  logic [33:0] mon;
  int miscompares = 0;
  int samples_checked = 0;
  // Row: mode byte, retire kind flags (3 hex digits), return type, expected event byte.
  localparam logic [31:0] ROWS [16] = '{
    32'h02100002, 32'h04180004, 32'h04100000, 32'h04140000, 32'h04120000, 32'h04108000,
    32'h08140008, 32'h08120008, 32'h08001008, 32'h10108010, 32'h40150040, 32'h40108240,
    32'h40108100, 32'h00104000, 32'h80104080, 32'h00102080};
  assign mon = {trace_fault_req, fault_pending, trace_ctrl_reg};
  always #20 core_clk = ~core_clk;
  tef_trace_ctrl i_dut (.core_clk(core_clk), .rst(rst), .retire(retire), .access('0),
    .ret_next(ret_next), .ret_next_frame_preret(ret_next_frame_preret),
    .boundary(boundary), .fault_ack(fault_ack), .intr_enter(intr_enter),
    .intr_return(intr_return), .fault_return(fault_return),
    .super_sp_trace_bit(super_sp_trace_bit),
    .tc_mod_en(tc_mod_en), .tc_mod_mask(tc_mod_mask), .tc_mod_val(tc_mod_val),
    .trace_en_wr(trace_en_wr), .trace_en_val(trace_en_val),
    .instruction_breakpoint_regs('0), .instruction_breakpoint_en(ibp_en),
    .data_breakpoint_regs('0), .trace_ctrl_reg(trace_ctrl_reg),
    .trace_enable(trace_enable), .fault_pending(fault_pending),
    .frame_preret_set(frame_preret_set), .frame_preret_set_current(frame_preret_set_current),
    .frame_rtype_bit0_wr(frame_rtype_bit0_wr), .frame_rtype_bit0(frame_rtype_bit0),
    .trace_fault_req(trace_fault_req), .trace_fault_subtype(trace_fault_subtype));
  tef_seq_model i_seq (.core_clk(core_clk), .rst(rst), .slow(slow),
    .trace_fault_req(trace_fault_req), .fault_ack(fault_ack));
  task tick;
    @(negedge core_clk);
  endtask : tick
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task cmp1(input string n, input logic e, input logic g);
    cmp(n, 32'(e), 32'(g));
  endtask : cmp1
  task mod(input logic [31:0] v);
    tc_mod_en = 1'b1;
    tc_mod_val = v;
    tick();
    tc_mod_en = 1'b0;
  endtask : mod
  task set_te(input logic v);
    trace_en_wr = 1'b1;
    trace_en_val = v;
    tick();
    trace_en_wr = 1'b0;
  endtask : set_te
  task retire_one(input logic [8:0] k, input logic [2:0] t);
    retire = {k, t, 32'h00000000};
    tick();
    retire = '0;
  endtask : retire_one
  task wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (mon[k] !== v) begin
      n++;
      if (n > 20) begin
        miscompares++;
        give_verdict();
      end
      tick();
    end
    samples_checked++;
  endtask : wait_for
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    cmp("tc rst", 32'h00000000, trace_ctrl_reg);
    foreach (ROWS[i]) begin
      mod({24'h000000, ROWS[i][31:24]});
      retire_one(ROWS[i][20:12], ROWS[i][10:8]);
      cmp("flg", 32'(ROWS[i][7:0]), 32'(trace_ctrl_reg[23:16]));
    end
    // Fault path across an interrupt, with a boundary while the ack is outstanding.
    mod(32'h00000002);
    set_te(1'b1);
    slow = 1'b1;
    retire_one(9'h100, 3'h0);
    cmp1("pend", 1'b1, fault_pending);
    intr_enter = 1'b1;
    tick();
    intr_enter = 1'b0;
    cmp1("pend intr", 1'b0, fault_pending);
    intr_return = 1'b1;
    tick();
    intr_return = 1'b0;
    cmp1("te intr ret", 1'b1, trace_enable);
    boundary = 1'b1;
    tick();
    cmp1("req", 1'b1, trace_fault_req);
    cmp("sub", 32'h00000002, 32'(trace_fault_subtype));
    tick();
    boundary = 1'b0;
    cmp1("req again", 1'b0, trace_fault_req);
    wait_for(32, 1'b0);
    cmp1("te ack", 1'b0, trace_enable);
    cmp("flg ack", 32'h00000000, 32'(trace_ctrl_reg[23:16]));
    mod(32'h00000000);
    set_te(1'b1);
    retire_one(9'h110, 3'h0);
    cmp1("rtype wr", 1'b1, frame_rtype_bit0_wr);
    cmp1("rtype", 1'b1, frame_rtype_bit0);
    cmp1("te svc", 1'b0, trace_enable);
    retire_one(9'h108, 3'h3);
    cmp1("te sret", 1'b1, trace_enable);
    mod(32'h00000002);
    retire_one(9'h100, 3'h0);
    set_te(1'b0);
    boundary = 1'b1;
    tick();
    boundary = 1'b0;
    cmp("flg off", 32'h00000000, 32'(trace_ctrl_reg[23:16]));
    cmp1("no req", 1'b0, trace_fault_req);
    // A prereturn that meets another event waits for the handler return.
    mod(32'h00000022);
    ret_next = 1'b1;
    ret_next_frame_preret = 1'b1;
    retire_one(9'h100, 3'h0);
    ret_next = 1'b0;
    ret_next_frame_preret = 1'b0;
    cmp("flg defer", 32'h00000002, 32'(trace_ctrl_reg[23:16]));
    fault_return = 1'b1;
    tick();
    fault_return = 1'b0;
    cmp("flg preret", 32'h00000022, 32'(trace_ctrl_reg[23:16]));
    mod(32'h00000028);
    ret_next = 1'b1;
    ret_next_frame_preret = 1'b1;
    wait_for(21, 1'b1);
    ret_next = 1'b0;
    ret_next_frame_preret = 1'b0;
    ibp_en = 2'h1;
    mod(32'h00000080);
    retire_one(9'h100, 3'h0);
    ibp_en = 2'h0;
    cmp("flg bp", 32'h00000080, 32'(trace_ctrl_reg[23:16]));
    cmp("hw bp", 32'h00000001, 32'(trace_ctrl_reg[27:24]));
    set_te(1'b1);
    rst = 1'b1;
    tick();
    tick();
    cmp("tc mid rst", 32'h00000000, trace_ctrl_reg);
    cmp1("te mid rst", 1'b0, trace_enable);
    rst = 1'b0;
    tick();
    give_verdict();
  end
endmodule : tef_trace_ctrl_bench
`default_nettype wire
